/* File: hw/asc_pkg.sv */
// constants and carrier types for the converter sequence control register
// Overview of operation
// - three-bit reference field picks fixed high/low reference pair per code
// - offset calibration ties both sample-and-hold inputs to low reference
// - without calibration, inputs follow channel select or scan select contents
// - scan control set scans selected inputs; cleared uses fixed channel
// - split mode fill status: 1 filling upper half, 0 filling lower half
// - interrupt after rate field plus one completed sequences
// - split mode: result store is two eight-word halves
// - non-split mode: result store is one sixteen-word buffer
// - alternate mode: first sample uses set A, then B, A alternately
// - alternate disabled: every sample uses set A
// - unimplemented bits 11, 9-8, 6 and upper half read as zero
package asc_pkg;
   localparam logic [11:0] ADDR_CTRL   = 12'h000;
   localparam logic [11:0] ADDR_STATUS = 12'h004;
   localparam int REF_LSB    = 13;
   localparam int OFFSET_CAL_ENABLE_BIT = 12;
   localparam int SCAN_BIT   = 10;
   localparam int FILL_BIT   = 7;
   localparam int RATE_LSB   = 2;
   localparam int SPLIT_BIT  = 1;
   localparam int ALT_BIT    = 0;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] CTRL_WMASK = 32'h0000_F43F;
   localparam logic [3:0]  HALF_WORDS = 4'h8;
   // reference pair codes
   localparam logic [1:0] REF_SUPPLY   = 2'h0;
   localparam logic [1:0] REF_EXTERNAL = 2'h1;
   // input routing source
   typedef enum logic [1:0] {ASC_SRC_CHANNEL, ASC_SRC_SCAN, ASC_SRC_LOWREF} asc_src_e;
   // settings carried to the sequencer
   typedef struct packed {
      logic     high_ref_ext;
      logic     low_ref_ext;
      asc_src_e pos_src;
      asc_src_e neg_src;
      logic     mux_set_b;
      logic     split_buffer_mode;
   } asc_cfg_s;
endpackage : asc_pkg

/* File: hw/asc_sequence_control.sv */
// control register and sequencing state for the converter sequence control
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module asc_sequence_control (
   // clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // apb slave
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [11:0]      paddr,
   input  wire logic [31:0]      pwdata,
   output logic      [31:0]      prdata,
   output logic                  pready,
   output logic                  pslverr,
   // sequencer events, one-cycle pulses
   input  wire logic             sample_done,
   input  wire logic             seq_done,
   // sequencer side
   output asc_pkg::asc_cfg_s     cfg,
   output logic      [3:0]       wr_addr,
   output logic                  seq_irq
);
   // control fields, one register for each implemented field
   logic [2:0]        ref_sel_r;
   logic [2:0]        ref_sel_nxt;
   logic              offset_cal_enable_r;
   logic              offset_cal_enable_nxt;
   logic              scan_r;
   logic              scan_nxt;
   logic [3:0]        rate_r;
   logic [3:0]        rate_nxt;
   logic              split_r;
   logic              split_nxt;
   logic              alt_r;
   logic              alt_nxt;
   // sequencing state
   logic [3:0]        seq_cnt_r;
   logic [3:0]        seq_cnt_nxt;
   logic [3:0]        wr_ptr_r;
   logic [3:0]        wr_ptr_nxt;
   logic              fill_r;
   logic              fill_nxt;
   logic              alt_b_r;
   logic              alt_b_nxt;
   logic              irq_r;
   logic              irq_nxt;
   // bus answer
   logic [31:0]       prdata_r;
   logic [31:0]       prdata_nxt;
   logic              pready_r;
   logic              pready_nxt;
   logic              pslverr_r;
   logic              pslverr_nxt;
   // settings handed to the sequencer
   asc_pkg::asc_cfg_s cfg_r;
   asc_pkg::asc_cfg_s cfg_nxt;

   // bus decode; a request is taken once, while pready is still low
   logic              access;
   logic              hit_ctrl;
   logic              hit_stat;
   logic              wr_ctrl;
   logic              rd_req;
   logic              bad_addr;
   assign access   = psel & penable & ~pready_r;
   assign hit_ctrl = (paddr == asc_pkg::ADDR_CTRL);
   assign hit_stat = (paddr == asc_pkg::ADDR_STATUS);
   assign wr_ctrl  = access & pwrite & hit_ctrl;
   assign rd_req   = access & ~pwrite;
   assign bad_addr = ~hit_ctrl & ~hit_stat;

   // control field updates; only implemented bits are stored
   assign ref_sel_nxt = wr_ctrl ? pwdata[asc_pkg::REF_LSB +: 3] : ref_sel_r;
   assign offset_cal_enable_nxt  = wr_ctrl ? pwdata[asc_pkg::OFFSET_CAL_ENABLE_BIT] : offset_cal_enable_r;
   assign scan_nxt    = wr_ctrl ? pwdata[asc_pkg::SCAN_BIT] : scan_r;
   assign rate_nxt    = wr_ctrl ? pwdata[asc_pkg::RATE_LSB +: 4] : rate_r;
   assign split_nxt   = wr_ctrl ? pwdata[asc_pkg::SPLIT_BIT] : split_r;
   assign alt_nxt     = wr_ctrl ? pwdata[asc_pkg::ALT_BIT] : alt_r;

   // readback words; unimplemented positions stay low
   logic              fill_vis;
   logic [31:0]       ctrl_rd;
   logic [31:0]       stat_rd;
   logic [31:0]       rd_mux;
   assign fill_vis = fill_r & split_r;
   assign ctrl_rd  = ({29'h0000_0000, ref_sel_r} << asc_pkg::REF_LSB)
                   | ({31'h0000_0000, offset_cal_enable_r} << asc_pkg::OFFSET_CAL_ENABLE_BIT)
                   | ({31'h0000_0000, scan_r} << asc_pkg::SCAN_BIT)
                   | ({31'h0000_0000, fill_vis} << asc_pkg::FILL_BIT)
                   | ({28'h000_0000, rate_r} << asc_pkg::RATE_LSB)
                   | ({31'h0000_0000, split_r} << asc_pkg::SPLIT_BIT)
                   | ({31'h0000_0000, alt_r} << asc_pkg::ALT_BIT);
   assign stat_rd  = {24'h00_0000, seq_cnt_r, wr_ptr_r};
   assign rd_mux   = hit_ctrl ? ctrl_rd
                   : hit_stat ? stat_rd
                   : 32'h0000_0000;

   // bus answer one cycle after the request is taken
   assign pready_nxt  = access;
   assign pslverr_nxt = access & bad_addr;
   assign prdata_nxt  = rd_req ? rd_mux : 32'h0000_0000;

   // reference pair per code; codes four to seven fall back to the supplies
   logic              ref_upper;
   logic              hi_ext;
   logic              lo_ext;
   assign ref_upper = ref_sel_r[2];
   assign hi_ext    = ~ref_upper & ref_sel_r[0];
   assign lo_ext    = ~ref_upper & ref_sel_r[1];

   // sample-and-hold input source; calibration overrides scan and channel
   asc_pkg::asc_src_e norm_src;
   asc_pkg::asc_src_e in_src;
   assign norm_src = scan_r ? asc_pkg::ASC_SRC_SCAN : asc_pkg::ASC_SRC_CHANNEL;
   assign in_src   = offset_cal_enable_r ? asc_pkg::ASC_SRC_LOWREF : norm_src;

   // sequence counting; the group ends when the count meets the rate field
   logic              cnt_hit;
   logic              group_end;
   logic [3:0]        cnt_inc;
   assign cnt_hit     = (seq_cnt_r == rate_r);
   assign group_end   = seq_done & cnt_hit;
   assign cnt_inc     = seq_cnt_r + 4'h1;
   assign seq_cnt_nxt = wr_ctrl ? 4'h0
                      : group_end ? 4'h0
                      : seq_done ? cnt_inc
                      : seq_cnt_r;
   assign irq_nxt     = group_end;

   // next write location: whole store, or wrap inside the active half
   logic [3:0]        ptr_inc;
   logic [3:0]        half_mask;
   logic [3:0]        half_base;
   logic [3:0]        other_base;
   logic [3:0]        split_step;
   logic [3:0]        step_ptr;
   logic [3:0]        group_base;
   assign ptr_inc    = wr_ptr_r + 4'h1;
   assign half_mask  = asc_pkg::HALF_WORDS - 4'h1;
   assign half_base  = fill_r ? asc_pkg::HALF_WORDS : 4'h0;
   assign other_base = fill_r ? 4'h0 : asc_pkg::HALF_WORDS;
   assign split_step = half_base | (ptr_inc & half_mask);
   assign step_ptr   = split_r ? split_step : ptr_inc;
   assign group_base = split_r ? other_base : 4'h0;
   assign wr_ptr_nxt = wr_ctrl ? 4'h0
                     : group_end ? group_base
                     : sample_done ? step_ptr
                     : wr_ptr_r;

   // fill half flips at each group end in split mode
   assign fill_nxt = wr_ctrl ? 1'b0
                   : (group_end & split_r) ? ~fill_r
                   : fill_r;

   // mux set phase: A for the first sample, then B and A in turn
   assign alt_b_nxt = (wr_ctrl | ~alt_r) ? 1'b0
                    : sample_done ? ~alt_b_r
                    : alt_b_r;

   // settings for the sequencer
   assign cfg_nxt = '{high_ref_ext:      hi_ext,
                      low_ref_ext:       lo_ext,
                      pos_src:           in_src,
                      neg_src:           in_src,
                      mux_set_b:         alt_b_r & alt_r,
                      split_buffer_mode: split_r};

   // reference field
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_sel_r <= asc_pkg::CTRL_RESET[asc_pkg::REF_LSB +: 3];
      end else begin
         ref_sel_r <= ref_sel_nxt;
      end
   end

   // offset calibration control
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         offset_cal_enable_r <= asc_pkg::CTRL_RESET[asc_pkg::OFFSET_CAL_ENABLE_BIT];
      end else begin
         offset_cal_enable_r <= offset_cal_enable_nxt;
      end
   end

   // input scan control
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scan_r <= asc_pkg::CTRL_RESET[asc_pkg::SCAN_BIT];
      end else begin
         scan_r <= scan_nxt;
      end
   end

   // sequences per interrupt
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rate_r <= asc_pkg::CTRL_RESET[asc_pkg::RATE_LSB +: 4];
      end else begin
         rate_r <= rate_nxt;
      end
   end

   // buffer mode control
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         split_r <= asc_pkg::CTRL_RESET[asc_pkg::SPLIT_BIT];
      end else begin
         split_r <= split_nxt;
      end
   end

   // alternate sampling control
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alt_r <= asc_pkg::CTRL_RESET[asc_pkg::ALT_BIT];
      end else begin
         alt_r <= alt_nxt;
      end
   end

   // sequence count within the current group
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seq_cnt_r <= 4'h0;
      end else begin
         seq_cnt_r <= seq_cnt_nxt;
      end
   end

   // result write pointer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_ptr_r <= 4'h0;
      end else begin
         wr_ptr_r <= wr_ptr_nxt;
      end
   end

   // half being filled
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fill_r <= 1'b0;
      end else begin
         fill_r <= fill_nxt;
      end
   end

   // mux set phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alt_b_r <= 1'b0;
      end else begin
         alt_b_r <= alt_b_nxt;
      end
   end

   // group interrupt pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= irq_nxt;
      end
   end

   // read data, zero outside a read answer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0000_0000;
      end else begin
         prdata_r <= prdata_nxt;
      end
   end

   // ready pulse, one wait state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
      end else begin
         pready_r <= pready_nxt;
      end
   end

   // error pulse for unmapped addresses
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr_r <= 1'b0;
      end else begin
         pslverr_r <= pslverr_nxt;
      end
   end

   // settings seen by the sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_r <= '0;
      end else begin
         cfg_r <= cfg_nxt;
      end
   end

   // outputs straight from their registers
   assign prdata  = prdata_r;
   assign pready  = pready_r;
   assign pslverr = pslverr_r;
   assign cfg     = cfg_r;
   assign wr_addr = wr_ptr_r;
   assign seq_irq = irq_r;
endmodule : asc_sequence_control
`default_nettype wire

/* File: testbench/asc_sequence_control_asserts.sv */
// assertion checker for the sequence control block
`timescale 1ns/1ps
`default_nettype none
module asc_sequence_control_asserts (
   // bus side
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   // sequencer side
   input wire logic        sample_done,
   input wire logic        seq_done,
   input wire logic        seq_irq,
   input wire logic [3:0]  wr_addr,
   input wire asc_pkg::asc_cfg_s cfg
);
   logic [15:0] c_r;
   logic [1:0]  s_r;
   wire         wr = psel && penable && pready && pwrite && paddr == 12'h000;
   wire         ok = s_r == 2'h3 && !penable;
   // shadow of control word, cycles since last write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         c_r <= 16'h0000;
         s_r <= 2'h3;
      end else begin
         c_r <= wr ? pwdata[15:0] & asc_pkg::CTRL_WMASK[15:0] : c_r;
         s_r <= wr ? 2'h0 : s_r + {1'b0, s_r != 2'h3};
      end
   end
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   rsvd_zero_a: assert property (pready && paddr == 12'h000 |-> (prdata & 32'hFFFF_0B40) == 0)
      else $error("reserved bits set");
   fill_off_a: assert property (pready && paddr == 12'h000 && !prdata[1] |-> !prdata[7])
      else $error("fill flag outside split");
   ref_pair_a: assert property (ok |-> cfg.high_ref_ext == (c_r[15:13] inside {1, 3})
      && cfg.low_ref_ext == (c_r[15:13] inside {2, 3})) else $error("reference pair");
   cal_src_a: assert property (ok && c_r[12] |-> cfg.pos_src == asc_pkg::ASC_SRC_LOWREF
      && cfg.neg_src == asc_pkg::ASC_SRC_LOWREF) else $error("calibration routing");
   scan_src_a: assert property (ok && !c_r[12] |-> cfg.pos_src == (c_r[10] ?
      asc_pkg::ASC_SRC_SCAN : asc_pkg::ASC_SRC_CHANNEL)) else $error("input routing");
   split_mode_a: assert property (ok |-> cfg.split_buffer_mode == c_r[1]) else $error("buffer mode");
   alt_off_a: assert property (ok && !c_r[0] |-> !cfg.mux_set_b) else $error("mux set");
   irq_rate_a: assert property (ok && c_r[5:2] == 0 && seq_done |=> seq_irq) else $error("irq late");
   half_swap_a: assert property (ok && c_r[1] && seq_irq |-> wr_addr == {~$past(wr_addr[3]), 3'h0})
      else $error("half swap");
   ptr_step_a: assert property (ok && !c_r[1] && sample_done && !seq_done
      |=> wr_addr == $past(wr_addr) + 4'h1) else $error("pointer step");
   // main scenarios reached
   irq_c: cover property (seq_irq);
   split_c: cover property (ok && c_r[1] && seq_irq);
   cal_c: cover property (ok && c_r[12]);
endmodule : asc_sequence_control_asserts
`default_nettype wire

/* File: testbench/asc_sequence_control_tb.sv */
// self-checking bench for the sequence control block
`timescale 1ns/1ps
`default_nettype none
module asc_sequence_control_tb;
   logic        pclk, presetn, psel, penable, pwrite, sample_done, seq_done, se;
   logic [11:0] paddr;
   logic [31:0] pwdata, rd, prdata;
   logic        pready, pslverr, seq_irq;
   logic [3:0]  wr_addr;
   asc_pkg::asc_cfg_s cfg;
   int          bad_count, cmp_count, irqs;
   asc_sequence_control u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sample_done(sample_done), .seq_done(seq_done), .cfg(cfg), .wr_addr(wr_addr), .seq_irq(seq_irq));
   // clock and interrupt tally
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   always @(posedge pclk) if (seq_irq === 1'b1) irqs++;
   task chk(input string s, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %s exp %h got %h", s, e, g);
      end
   endtask : chk
   task complete_run;
      if (bad_count == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : complete_run
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge pclk);
      chk("pready", 1, pready);
      if (n == 20) complete_run;
      {rd, se} = {prdata, pslverr};
      {psel, penable} <= 2'b00;
   endtask : apb
   task pulse(input logic s);
      @(posedge pclk);
      {sample_done, seq_done} <= {s, !s};
      @(posedge pclk);
      {sample_done, seq_done} <= 2'b00;
   endtask : pulse
   task s_regs;
      apb(0, 12'h000, 0);
      chk("ctl_rst", 0, rd);
      apb(1, 12'h000, 32'hFFFF_FFFF);
      apb(0, 12'h000, 0);
      chk("ctl_mask", 32'h0000_F43F, rd);
      apb(0, 12'h008, 0);
      chk("unmapped", 0, rd);
      chk("slverr", 1, se);
   endtask : s_regs
   task s_ref;
      for (int v = 0; v < 8; v++) begin
         apb(1, 12'h000, {16'h0000, v[2:0], v[0], 12'h000});
         repeat (2) @(posedge pclk);
         chk("hi_ref", v == 1 || v == 3, cfg.high_ref_ext);
         chk("lo_ref", v == 2 || v == 3, cfg.low_ref_ext);
         chk("src", v[0] ? asc_pkg::ASC_SRC_LOWREF : asc_pkg::ASC_SRC_CHANNEL, cfg.neg_src);
      end
      apb(1, 12'h000, 32'h0000_0400);
      repeat (2) @(posedge pclk);
      chk("scan", asc_pkg::ASC_SRC_SCAN, cfg.pos_src);
   endtask : s_ref
   task s_irq(input logic [3:0] r);
      apb(1, 12'h000, {26'h0, r, 2'h2});
      irqs = 0;
      for (int i = 0; i < r; i++) pulse(0);
      chk("early", 0, irqs);
      pulse(0);
      repeat (2) @(posedge pclk);
      chk("irqs", 1, irqs);
      apb(0, 12'h004, 0);
      chk("half", 8, rd[3:0]);
      chk("split", 1, cfg.split_buffer_mode);
      apb(0, 12'h000, 0);
      chk("fill", 1, rd[7]);
   endtask : s_irq
   task s_ptr;
      apb(1, 12'h000, 32'h0000_0000);
      pulse(1);
      repeat (2) @(posedge pclk);
      chk("mux_a", 0, cfg.mux_set_b);
      chk("unsplit", 0, cfg.split_buffer_mode);
      apb(1, 12'h000, 32'h0000_0001);
      for (int i = 1; i < 4; i++) begin
         pulse(1);
         repeat (2) @(posedge pclk);
         chk("mux_b", i[0], cfg.mux_set_b);
      end
      chk("ptr", 3, wr_addr);
   endtask : s_ptr
   task s_wrap;
      apb(1, 12'h000, 32'h0000_0002);
      repeat (9) pulse(1);
      @(posedge pclk);
      chk("wrap", 1, wr_addr);
   endtask : s_wrap
   initial begin
      {presetn, psel, penable, pwrite, sample_done, seq_done, paddr, pwdata} = '0;
      {bad_count, cmp_count, irqs} = '0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      s_regs;
      s_ref;
      s_irq(4'h0);
      s_irq(4'hF);
      s_ptr;
      s_wrap;
      complete_run;
   end
endmodule : asc_sequence_control_tb
bind asc_sequence_control asc_sequence_control_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .sample_done(sample_done), .seq_done(seq_done), .seq_irq(seq_irq), .wr_addr(wr_addr), .cfg(cfg));
`default_nettype wire
